// *** logic/dpo_pkg.sv ***
`default_nettype none
package dpo_pkg;

  // Sample and port geometry
  localparam int unsigned SAMPLE_W   = 32;
  localparam int unsigned NUM_WORDS  = 4;
  localparam int unsigned SEG_W      = 16;
  localparam int unsigned SEL_W      = 3;
  localparam int unsigned BUNDLE_W   = SAMPLE_W * NUM_WORDS;
  localparam int unsigned FIFO_DEPTH = 8;
  localparam int unsigned PERIOD_W   = 16;

  // Word order inside a sample bundle and inside the select code
  localparam int unsigned WORD_IA = 0;
  localparam int unsigned WORD_QA = 1;
  localparam int unsigned WORD_IB = 2;
  localparam int unsigned WORD_QB = 3;

  // Select code field positions: bit 0 picks the lower half
  localparam int unsigned SEL_HALF_BIT = 0;
  localparam int unsigned SEL_WORD_LSB = 1;
  localparam int unsigned SEL_WORD_MSB = 2;

  // Rounding constants for the fixed-point formats
  localparam logic [SAMPLE_W-1:0] RND16_HALF = 32'h0000_8000;
  localparam logic [SAMPLE_W-1:0] RND16_MASK = 32'hFFFF_0000;
  localparam logic [SAMPLE_W-1:0] RND24_HALF = 32'h0000_0080;
  localparam logic [SAMPLE_W-1:0] RND24_MASK = 32'hFFFF_FF00;
  localparam logic [SAMPLE_W-1:0] POS_MAX    = 32'h7FFF_FFFF;

  // Floating-point layout: 4 zero bits, 4-bit exponent, 8-bit mantissa
  localparam int unsigned EXP_W   = 4;
  localparam int unsigned MANT_W  = 8;
  localparam logic [3:0]  EXP_MAX = 4'hF;

  // Reset values
  localparam logic [PERIOD_W-1:0] GAP_RST  = 16'h0000;
  localparam logic [SEG_W-1:0]    SEG_RST  = 16'h0000;
  localparam logic [SAMPLE_W-1:0] WORD_RST = 32'h0000_0000;

  // Output number formats
  typedef enum logic [1:0] {
    FMT_ROUND16,
    FMT_ROUND24,
    FMT_FULL32,
    FMT_FLOAT
  } dpo_fmt_e;

endpackage
`default_nettype wire

// *** logic/dpo_fifo_if.sv ***
`default_nettype none
interface dpo_fifo_if;
  import dpo_pkg::*;

  logic                push_valid;
  logic                push_ready;
  logic [BUNDLE_W-1:0] push_data;
  logic                pop_valid;
  logic                pop_ready;
  logic [BUNDLE_W-1:0] pop_data;

  modport fifo (
    input  push_valid, push_data, pop_ready,
    output push_ready, pop_valid, pop_data
  );

  modport user (
    output push_valid, push_data, pop_ready,
    input  push_ready, pop_valid, pop_data
  );
endinterface
`default_nettype wire

// *** logic/dpo_fifo.sv ***
`default_nettype none
module dpo_fifo
  import dpo_pkg::*;
#(
  parameter int unsigned WIDTH = BUNDLE_W,
  parameter int unsigned DEPTH = FIFO_DEPTH
) (
  input  wire logic core_clk_i,   // Core clock
  input  wire logic rst_i,        // Async reset, active high
  dpo_fifo_if.fifo  q             // Push and pop sides
);

  localparam int unsigned PTR_W = $clog2(DEPTH);
  localparam logic [PTR_W:0] CNT_FULL = (PTR_W+1)'(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PTR_W-1:0] wr_q;
  logic [PTR_W-1:0] rd_q;
  logic [PTR_W:0]   cnt_q;
  logic             ov_q;
  logic [WIDTH-1:0] od_q;
  logic             do_push;
  logic             load;
  logic             from_mem;
  logic             bypass;
  logic             mem_wr;

  // Output stage does not count toward depth; only the memory entries do
  assign q.push_ready = (cnt_q != CNT_FULL);
  assign do_push      = q.push_valid && q.push_ready;
  assign load         = !ov_q || q.pop_ready;
  assign from_mem     = load && (cnt_q != '0);
  assign bypass       = load && (cnt_q == '0) && do_push;
  assign mem_wr       = do_push && !bypass;
  assign q.pop_valid  = ov_q;
  assign q.pop_data   = od_q;

  // Storage array, no reset needed on data
  always_ff @(posedge core_clk_i) begin
    if (mem_wr) begin
      mem_q[wr_q] <= q.push_data;
    end
  end

  // Pointers and fill count
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (mem_wr) begin
        wr_q <= PTR_W'(wr_q + 1'b1);
      end
      if (from_mem) begin
        rd_q <= PTR_W'(rd_q + 1'b1);
      end
      if (mem_wr && !from_mem) begin
        cnt_q <= (PTR_W+1)'(cnt_q + 1'b1);
      end else if (!mem_wr && from_mem) begin
        cnt_q <= (PTR_W+1)'(cnt_q - 1'b1);
      end
    end
  end

  // Registered read stage keeps read data off the array mux
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ov_q <= 1'b0;
      od_q <= '0;
    end else if (load) begin
      ov_q <= from_mem || bypass;
      if (from_mem) begin
        od_q <= mem_q[rd_q];
      end else if (bypass) begin
        od_q <= q.push_data;
      end
    end
  end

endmodule
`default_nettype wire

// *** logic/dpo_port.sv ***
// Notes on behaviour
// R1: Select code picks upper/lower half of IA, QA, IB, QB; float lowers read zero.
// R2: Data pins driven only while the active-low drive enable is low.
// R3: Ready pulses once at the start of every output sample period.
// R4: Reader must fetch all needed segments within one period after ready.
// R5: Configuring party keeps each period at least five serial clock periods.
// R6: Fixed-point formats round to 16 or 24 bits, or give full 32 bits.
// R7: With 32-bit words, reading the upper segment's top byte gives 8-bit truncation.
// R8: Fixed-point valid bits sit at the top, lower bits forced to zero.
// R9: Float is four zeros, 4-bit exponent, 8-bit mantissa in the upper segment.
// R10: All presented values are two's complement.
// R11: Sample set latched at period start and held stable until the next.
`default_nettype none
module dpo_port
  import dpo_pkg::*;
(
  input  wire logic                core_clk_i,           // Core clock, 100 MHz
  input  wire logic                rst_i,                // Async reset, active high
  input  wire logic                sample_valid_i,       // New I/Q sample set offered
  input  wire logic [BUNDLE_W-1:0] sample_data_i,        // {QB, IB, QA, IA}, 32 bits each
  output logic                     sample_ready_o,       // Buffer can take a sample set
  input  wire logic [1:0]          format_i,             // Output number format
  input  wire logic [PERIOD_W-1:0] period_len_i,         // Output sample period in clocks
  input  wire logic [SEL_W-1:0]    segment_select_i,     // Segment select code
  input  wire logic                port_drive_enable_n_i, // Low drives the data pins
  output logic [SEG_W-1:0]         pout_o,               // Parallel data out
  output logic                     pout_oe_o,            // High while pins are driven
  output logic                     ready_o               // Period start pulse
);

  dpo_fifo_if fq ();

  logic [PERIOD_W-1:0] gap_q;
  logic                take;
  logic                ready_q;
  logic [SEG_W-1:0]    pout_q;
  logic [SAMPLE_W-1:0] word_q [NUM_WORDS];
  dpo_fmt_e            fmt;
  logic [1:0]          widx;

  // Round half up, saturating at positive full scale
  function automatic logic [SAMPLE_W-1:0] round_word(
    input logic [SAMPLE_W-1:0] x,
    input logic [SAMPLE_W-1:0] half,
    input logic [SAMPLE_W-1:0] mask
  );
    logic [SAMPLE_W-1:0] s;
    s = SAMPLE_W'(x + half);
    if (!x[SAMPLE_W-1] && s[SAMPLE_W-1]) begin
      round_word = POS_MAX & mask;       // Overflow would flip the sign [R10]
    end else begin
      round_word = s & mask;             // Low bits cleared [R8]
    end
  endfunction

  // Normalise by stripping redundant sign bits, exponent capped at four bits
  function automatic logic [SEG_W-1:0] float_word(
    input logic [SAMPLE_W-1:0] x
  );
    logic [4:0]          n;
    logic                found;
    logic [3:0]          sh;
    logic [SAMPLE_W-1:0] y;
    logic [EXP_W-1:0]    e;
    n     = 5'h00;
    found = 1'b0;
    for (int i = SAMPLE_W - 2; i >= 0; i--) begin
      if (!found && (x[i] == x[SAMPLE_W-1])) begin
        n = 5'(n + 1'b1);
      end else begin
        found = 1'b1;
      end
    end
    sh = (n > 5'(EXP_MAX)) ? EXP_MAX : n[3:0];
    y  = x << sh;                         // Mantissa keeps the sign [R10]
    e  = 4'(EXP_MAX - sh);
    float_word = {4'h0, e, y[SAMPLE_W-1 -: MANT_W]}; // Zeros, exponent, mantissa [R9]
  endfunction

  // Buffer between the filter chain and the read-out latches
  dpo_fifo #(
    .WIDTH (BUNDLE_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .q          (fq.fifo)
  );

  assign fq.push_valid = sample_valid_i;
  assign fq.push_data  = sample_data_i;
  assign sample_ready_o = fq.push_ready;

  // Drain only once per period so a reader never sees data change early
  assign fq.pop_ready = (gap_q == GAP_RST);
  assign take         = fq.pop_valid && fq.pop_ready;
  assign fmt          = dpo_fmt_e'(format_i);

  // Period timer: reloaded on each new sample set
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      gap_q <= GAP_RST;
    end else if (take) begin
      if (period_len_i == GAP_RST) begin
        gap_q <= GAP_RST;
      end else begin
        gap_q <= PERIOD_W'(period_len_i - 1'b1);
      end
    end else if (gap_q != GAP_RST) begin
      gap_q <= PERIOD_W'(gap_q - 1'b1);
    end
  end

  // Ready pulse, one clock, in step with the latch update
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ready_q <= 1'b0;
    end else begin
      ready_q <= take;                  // [R3]
    end
  end

  assign ready_o = ready_q;

  // Per-word format and latch; format is sampled with the data
  for (genvar k = 0; k < NUM_WORDS; k++) begin : g_word
    logic [SAMPLE_W-1:0] raw;
    logic [SAMPLE_W-1:0] fmtd;

    assign raw = fq.pop_data[k*SAMPLE_W +: SAMPLE_W];

    // Formatting choice for this word
    always_comb begin
      case (fmt)
        FMT_ROUND16: fmtd = round_word(raw, RND16_HALF, RND16_MASK); // [R6] [R8]
        FMT_ROUND24: fmtd = round_word(raw, RND24_HALF, RND24_MASK); // [R6] [R8]
        FMT_FULL32:  fmtd = raw;                  // Top byte alone is an 8-bit cut [R6] [R7]
        FMT_FLOAT:   fmtd = {float_word(raw), 16'h0000}; // Lower half reads zero [R1] [R9]
        default:     fmtd = raw;
      endcase
    end

    // Held for the whole period so segments stay coherent
    always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
        word_q[k] <= WORD_RST;
      end else if (take) begin
        word_q[k] <= fmtd;              // [R11]
      end
    end
  end

  // Segment mux, registered so the pins come from flip-flops
  assign widx = segment_select_i[SEL_WORD_MSB:SEL_WORD_LSB];

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pout_q <= SEG_RST;
    end else if (segment_select_i[SEL_HALF_BIT]) begin
      pout_q <= word_q[widx][SEG_W-1:0];        // Lower half [R1]
    end else begin
      pout_q <= word_q[widx][SAMPLE_W-1:SEG_W]; // Upper half [R1]
    end
  end

  assign pout_o = pout_q;

  // Bus sharing: enable follows the pin directly, no pipeline
  assign pout_oe_o = !port_drive_enable_n_i;   // [R2]

endmodule
`default_nettype wire

// *** tb/dpo_port_assertions.sv ***
`default_nettype none
module dpo_port_checker
  import dpo_pkg::*;
(
  input wire logic                core_clk_i,            // Clock
  input wire logic                rst_i,                 // Reset
  input wire logic [1:0]          format_i,              // Format
  input wire logic [PERIOD_W-1:0] period_len_i,          // Period
  input wire logic [SEL_W-1:0]    segment_select_i,      // Select
  input wire logic                port_drive_enable_n_i, // Drive enable
  input wire logic [SEG_W-1:0]    pout_o,                // Port data
  input wire logic                pout_oe_o,             // Pin enable
  input wire logic                ready_o                // Period start
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  logic [1:0]          fmt_prev_q;
  logic [1:0]          fmt_lat_q;
  logic [PERIOD_W-1:0] gap_q;
  logic                seen_q;
  logic [PERIOD_W-1:0] plen_prev_q;
  logic [PERIOD_W-1:0] plen_lat_q;
  // Format and period of the held set; both are sampled on the latch edge
  // Period may change between batches, so the gap is judged by the old one
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      fmt_prev_q  <= 2'h0;
      fmt_lat_q   <= 2'h0;
      plen_prev_q <= 16'h0000;
      plen_lat_q  <= 16'h0000;
    end else begin
      fmt_prev_q  <= format_i;
      plen_prev_q <= period_len_i;
      if (ready_o) begin
        fmt_lat_q  <= fmt_prev_q;
        plen_lat_q <= plen_prev_q;
      end
    end
  end
  // Cycles since the last ready, saturating so a long stall cannot wrap
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      gap_q  <= 16'h0001;
      seen_q <= 1'b0;
    end else if (ready_o) begin
      gap_q  <= 16'h0001;
      seen_q <= 1'b1;
    end else if (gap_q != 16'hFFFF) begin
      gap_q <= gap_q + 16'h0001;
    end
  end
  sequence s_pulse;
    ready_o ##1 !ready_o;
  endsequence
  oe_match_a: assert property (pout_oe_o == !port_drive_enable_n_i)
    else $error("pin enable does not follow drive enable");
  pulse_once_a: assert property (ready_o && period_len_i > 16'h0001 |-> s_pulse)
    else $error("ready longer than one cycle");
  ready_gap_a: assert property (ready_o && seen_q |-> gap_q >= plen_lat_q)
    else $error("ready pulses closer than one period");
  hold_steady_a: assert property ($changed(pout_o) |-> $past(ready_o)
    || $past(segment_select_i) != $past(segment_select_i, 2))
    else $error("port data moved without a new select or sample");
  float_low_a: assert property (fmt_lat_q == 2'h3 && $past(segment_select_i[0])
    |-> pout_o == 16'h0000) else $error("float lower segment not zero");
  float_top_a: assert property (fmt_lat_q == 2'h3 |-> pout_o[15:12] == 4'h0)
    else $error("float top nibble not zero");
  round16_low_a: assert property (fmt_lat_q == 2'h0 && $past(segment_select_i[0])
    |-> pout_o == 16'h0000) else $error("16-bit lower segment not zero");
  round24_low_a: assert property (fmt_lat_q == 2'h1 && $past(segment_select_i[0])
    |-> pout_o[7:0] == 8'h00) else $error("24-bit low byte not zero");
endmodule
bind dpo_port dpo_port_checker u_dpo_port_checker (.core_clk_i, .rst_i, .format_i,
  .period_len_i, .segment_select_i, .port_drive_enable_n_i, .pout_o, .pout_oe_o, .ready_o);
`default_nettype wire

// *** tb/dpo_reader.sv ***
`default_nettype none
module dpo_reader
  import dpo_pkg::*;
(
  input  wire logic             core_clk_i, // Clock
  input  wire logic             rst_i,      // Reset
  input  wire logic             ready_i,    // Period start
  input  wire logic [SEG_W-1:0] pout_i,     // Port data
  output logic      [SEL_W-1:0] sel_o,      // Segment select
  output logic                  done_o,     // All segments taken
  output logic      [SEG_W-1:0] seg_o [8]   // Captured segments
);
  timeunit 1ns;
  timeprecision 1ps;
  logic             walk_q;
  logic             prev_ok_q;
  logic [SEL_W-1:0] prev_sel_q;
  // Step all eight codes right after ready, inside one period of ten or more clocks
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sel_o  <= 3'h0;
      walk_q <= 1'b0;
    end else if (ready_i) begin
      sel_o  <= 3'h0;
      walk_q <= 1'b1;
    end else if (walk_q) begin
      walk_q <= (sel_o != 3'h7);
      sel_o  <= sel_o + 3'h1;
    end
  end
  // Port data shows the code taken one edge earlier
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      prev_ok_q  <= 1'b0;
      prev_sel_q <= 3'h0;
      done_o     <= 1'b0;
    end else begin
      prev_ok_q  <= walk_q;
      prev_sel_q <= sel_o;
      done_o     <= prev_ok_q && prev_sel_q == 3'h7;
    end
  end
  // Capture store, no reset needed
  always_ff @(posedge core_clk_i) begin
    if (prev_ok_q) seg_o[prev_sel_q] <= pout_i;
  end
endmodule
`default_nettype wire

// *** tb/dpo_port_test.sv ***
`default_nettype none
module dpo_port_test
  import dpo_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic                core_clk_i, rst_i, sample_valid_i, sample_ready_o;
  logic                port_drive_enable_n_i = 1'b1;
  logic [PERIOD_W-1:0] period_len;
  logic [BUNDLE_W-1:0] sample_data_i;
  logic [1:0]          format_i;
  logic [SEL_W-1:0]    segment_select_i;
  logic [SEG_W-1:0]    pout_o;
  logic [SEG_W-1:0]    segs [8];
  logic                pout_oe_o, ready_o, done;
  logic [BUNDLE_W-1:0] q [$];
  int                  fail_count, n_compared, stalls, seed;
  dpo_port u_dpo_port (.core_clk_i, .rst_i, .sample_valid_i, .sample_data_i, .sample_ready_o,
    .format_i, .period_len_i(period_len), .segment_select_i, .port_drive_enable_n_i,
    .pout_o, .pout_oe_o, .ready_o);
  dpo_reader u_dpo_reader (.core_clk_i, .rst_i, .ready_i(ready_o), .pout_i(pout_o),
    .sel_o(segment_select_i), .done_o(done), .seg_o(segs));
  // Reference word per format: round half up with saturation, full 32-bit word, or float
  function automatic logic [31:0] ref_word(logic [31:0] x, logic [1:0] f);
    logic [31:0] s;
    int          n;
    n = 0;
    case (f)
      2'h0: s = x + 32'h0000_8000;
      2'h1: s = x + 32'h0000_0080;
      default: s = x;
    endcase
    if (f == 2'h0) return (!x[31] && s[31]) ? 32'h7FFF_0000 : s & 32'hFFFF_0000;
    if (f == 2'h1) return (!x[31] && s[31]) ? 32'h7FFF_FF00 : s & 32'hFFFF_FF00;
    if (f == 2'h2) return x;
    while (n < 31 && x[30-n] == x[31]) n++;
    if (n > 15) n = 15;
    s = x << n;
    return {4'h0, 4'(15 - n), s[31:24], 16'h0000};
  endfunction
  task automatic cmp(logic [15:0] got, logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("compared %0d failed %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end
  // Random drive enable each cycle; pins must track it
  always @(posedge core_clk_i) begin
    cmp({15'h0, pout_oe_o}, {15'h0, ~port_drive_enable_n_i});
    port_drive_enable_n_i <= 1'($random(seed));
  end
  // Each finished walk is one coherent set from the model queue
  always @(posedge core_clk_i) begin
    if (done === 1'b1) begin
      if (q.size() == 0) cmp(16'h0001, 16'h0000);
      else begin
        sample_data_i_chk(q.pop_front());
      end
    end
  end
  task automatic sample_data_i_chk(logic [BUNDLE_W-1:0] set);
    logic [31:0] w;
    for (int c = 0; c < 8; c++) begin
      w = ref_word(set[32*(c/2) +: 32], format_i);
      cmp(segs[c], c[0] ? w[15:0] : w[31:16]);
    end
  endtask
  // Batches of back-to-back sets per format, overfilling the buffer
  initial begin
    int k;
    seed = 51;
    rst_i = 1'b1;
    sample_valid_i = 1'b0;
    sample_data_i = '0;
    format_i = 2'h0;
    period_len = 16'h0010;
    repeat (4) @(posedge core_clk_i);
    rst_i <= 1'b0;
    for (int f = 0; f < 4; f++) begin
      format_i <= 2'(f);
      // Period varies per batch, never shorter than the reader's walk
      period_len <= 16'h000A + 16'(f * 6);
      sample_valid_i <= 1'b1;
      for (int i = 0; i < 12; i++) begin
        // First set of a batch hits saturation and the exponent cap
        sample_data_i <= (i == 0) ? {32'h7FFF_FFFF, 32'h8000_0000, 32'h0000_0000, 32'h7FFF_8000}
                                  : {$random(seed), $random(seed), $random(seed), $random(seed)};
        for (k = 0; k < 400; k++) begin
          @(posedge core_clk_i);
          if (sample_ready_o === 1'b1) break;
          stalls++;
        end
        if (k == 400) begin
          fail_count++;
          $display("CHECK FAILED %0t sample set never accepted", $time);
          wrap_up();
        end
        q.push_back(sample_data_i);
      end
      sample_valid_i <= 1'b0;
      for (k = 0; k < 2000 && q.size() > 0; k++) @(posedge core_clk_i);
      if (q.size() > 0) begin
        fail_count++;
        $display("CHECK FAILED %0t %0d sets never read out", $time, q.size());
        wrap_up();
      end
    end
    if (stalls == 0) cmp(16'h0000, 16'h0001);
    wrap_up();
  end
endmodule
`default_nettype wire
